// ==== src/opmode_pkg.sv ====
// Constants for the operating-mode controller of the system basis chip.
// Assumes a 40 MHz clk_sys; analog detectors arrive as digital levels.
`default_nettype none
package opmode_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Normal request time-out in ms
    localparam int unsigned NRTOUT_MS = 350;
    localparam int unsigned NRTOUT_CYC = NRTOUT_MS * (CLK_HZ / 1000);
    // Reset duration in ms (typical figure)
    localparam int unsigned RSTDUR_MS = 15;
    localparam int unsigned RSTDUR_CYC = RSTDUR_MS * (CLK_HZ / 1000);
    // Wake pulse on the interrupt output, in us
    localparam int unsigned WAKE_PULSE_US = 10;
    localparam int unsigned WAKE_PULSE_CYC =
        WAKE_PULSE_US * (CLK_HZ / 1_000_000);
    // Host mode requests
    localparam logic [1:0] REQ_NORMAL = 2'h0;
    localparam logic [1:0] REQ_STANDBY = 2'h1;
    localparam logic [1:0] REQ_STOP = 2'h2;
    localparam logic [1:0] REQ_SLEEP = 2'h3;
    // Reset values
    localparam logic RST_FLAG = 1'h0;
    typedef enum logic [2:0] {
        ST_RESET, ST_NREQ, ST_NORMAL, ST_STANDBY, ST_STOP, ST_SLEEP
    } mode_e;
endpackage : opmode_pkg
`default_nettype wire

// ==== src/opmode_ctrl.sv ====
// Operating-mode sequencer: regulator, switch and watchdog enables,
// fault flags, wake handling and reset output.
// Assumes host requests are clk_sys pulses; pins pass two flops first.
`default_nettype none
// Behaviour
// - Latch battery-fail flag below 3 V always
// - Early-warning interrupt only in normal/standby
// - Regulator overtemp sets temp warning, shuts regulator
// - Second-supply-low flag follows low detector
// - Switch overtemp reported in both registers
// - Switch follows on-bit in normal/standby
// - Cyclic switch timing in sleep/stop
// - Fast oscillator active modes, slow otherwise
// - Normal request after reset or stop wake
// - Standby: main regulator only, watchdog runs
// - Standby: no CAN transmit, rx sets wake
// - Normal: both regulators, watchdog runs
// - Stop: low-current main, listed wake sources
// - Stop by command; watchdog per stop bit
// - Sleep: regulators off, listed wake sources
// - Sleep wake passes through reset state
// - Reset holds output low for duration
// - Reset on undervoltage or watchdog faults
// - Power-up through reset; stop wake skips it
// - Normal request: main on, timer started
// - Time-out expiry without configuration resets, or returns to sleep after a sleep wake
// - Stop wake gives short interrupt low pulse
module opmode_ctrl
    import opmode_pkg::*;
#(
    parameter int unsigned NRTOUT_CYCLES = NRTOUT_CYC,
    parameter int unsigned RSTDUR_CYCLES = RSTDUR_CYC,
    parameter int unsigned CYCLIC_CYCLES = 40_000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Analog detectors (asynchronous levels)
    input wire logic battery_supply_fail,
    input wire logic battery_supply_warn,
    input wire logic regulator_overtemp,
    input wire logic second_regulator_low,
    input wire logic switch_overtemp,
    input wire logic main_undervoltage,
    input wire logic main_overcurrent,
    // Wake sources (asynchronous levels)
    input wire logic [3:0] level_wake_inputs,
    input wire logic can_rx_activity,
    input wire logic chip_select_n,
    input wire logic cyclic_wake,
    input wire logic forced_wake,
    // Host commands (clk_sys pulses)
    input wire logic mode_req_valid,
    input wire logic [1:0] mode_req,
    input wire logic watchdog_timing_write,
    input wire logic switch_on_bit,
    input wire logic watchdog_in_stop_bit,
    input wire logic watchdog_timeout,
    input wire logic watchdog_early_trigger,
    input wire logic flag_clear,
    // Enables and pins
    output logic main_regulator_en,
    output logic main_regulator_lowpwr,
    output logic second_regulator_drive,
    output logic high_side_switch,
    output logic watchdog_run,
    output logic can_tx_en,
    output logic fast_osc_sel,
    output logic reset_n,
    output logic interrupt_n,
    // Status
    output logic battery_fail_flag,
    output logic early_warn_flag,
    output logic regulator_temp_warning,
    output logic second_supply_low_flag,
    output logic switch_overtemp_flag,
    output logic switch_temp_or_supply_low_flag,
    output logic can_wake_flag,
    output logic [2:0] mode_state
);
    localparam int NS = 12;
    // Two-flop synchronisers for all pin levels
    logic [NS-1:0] pin_raw, s1_ff, s2_ff;
    assign pin_raw = {battery_supply_fail, battery_supply_warn,
        regulator_overtemp, second_regulator_low, switch_overtemp,
        main_undervoltage, main_overcurrent, can_rx_activity,
        chip_select_n, cyclic_wake, forced_wake, 1'b0};
    logic [3:0] lv1_ff, lv2_ff, lv3_ff;
    always_ff @(posedge clk_sys) begin
        s1_ff <= pin_raw;
        s2_ff <= s1_ff;
        lv1_ff <= level_wake_inputs;
        lv2_ff <= lv1_ff;
        lv3_ff <= lv2_ff;
    end
    logic bat_fail, bat_warn, reg_ot, v2_low, hs_ot, uv, oc, can_rx;
    logic cs_n, cyc_wk, frc_wk;
    assign {bat_fail, bat_warn, reg_ot, v2_low, hs_ot, uv, oc, can_rx,
        cs_n, cyc_wk, frc_wk} = s2_ff[NS-1:1];
    logic cs_prev_ff;
    logic level_change;
    assign level_change = (lv2_ff != lv3_ff);

    mode_e state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic from_sleep_ff, nxt_from_sleep;
    logic [15:0] pulse_ff, nxt_pulse;
    logic [31:0] cyc_ff, nxt_cyc;
    logic cyc_on_ff, nxt_cyc_on;
    logic stop_wake, sleep_wake, cs_rise;

    // Wake decoding for the two low-power modes
    assign cs_rise = cs_n && !cs_prev_ff; // Synced pin only, never raw
    assign stop_wake = cyc_wk || frc_wk || can_rx || level_change ||
        oc || cs_rise;
    assign sleep_wake = cyc_wk || frc_wk || can_rx || level_change;

    // Mode sequencing; reset faults take priority over host requests
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 32'h1;
        nxt_from_sleep = from_sleep_ff;
        nxt_pulse = (pulse_ff != 16'h0) ? pulse_ff - 16'h1 : 16'h0;
        case (state_ff)
            ST_RESET: begin
                if (cnt_ff >= RSTDUR_CYCLES - 1) begin
                    nxt_state = ST_NREQ;
                    nxt_cnt = 32'h0;
                end
            end
            ST_NREQ: begin
                if (uv) begin
                    nxt_state = ST_RESET;
                    nxt_cnt = 32'h0;
                end else if (watchdog_timing_write) begin
                    nxt_state = (mode_req_valid && mode_req == REQ_STANDBY)
                        ? ST_STANDBY : ST_NORMAL;
                    nxt_from_sleep = 1'b0;
                end else if (cnt_ff >= NRTOUT_CYCLES - 1) begin
                    // Sleep-origin request falls back to sleep
                    nxt_state = from_sleep_ff ? ST_SLEEP : ST_RESET;
                    nxt_cnt = 32'h0;
                end
            end
            ST_NORMAL, ST_STANDBY: begin
                if (uv || watchdog_timeout || watchdog_early_trigger) begin
                    nxt_state = ST_RESET;
                    nxt_cnt = 32'h0;
                end else if (mode_req_valid) begin
                    case (mode_req)
                        REQ_NORMAL: nxt_state = ST_NORMAL;
                        REQ_STANDBY: nxt_state = ST_STANDBY;
                        REQ_STOP: nxt_state = ST_STOP;
                        default: nxt_state = ST_SLEEP;
                    endcase
                end
            end
            ST_STOP: begin
                if (uv || (watchdog_in_stop_bit && watchdog_timeout)) begin
                    nxt_state = ST_RESET;
                    nxt_cnt = 32'h0;
                end else if (stop_wake) begin
                    nxt_state = ST_NREQ;
                    nxt_cnt = 32'h0;
                    nxt_from_sleep = 1'b0;
                    nxt_pulse = WAKE_PULSE_CYC[15:0];
                end
            end
            default: begin
                if (sleep_wake) begin
                    nxt_state = ST_RESET;
                    nxt_cnt = 32'h0;
                    nxt_from_sleep = 1'b1;
                end
            end
        endcase
    end

    // Cyclic switch timer, active in low-power modes only
    always_comb begin
        nxt_cyc = 32'h0;
        nxt_cyc_on = 1'b0;
        if (state_ff == ST_STOP || state_ff == ST_SLEEP) begin
            nxt_cyc = cyc_ff + 32'h1;
            nxt_cyc_on = cyc_on_ff;
            if (cyc_ff >= CYCLIC_CYCLES - 1) begin
                nxt_cyc = 32'h0;
                nxt_cyc_on = !cyc_on_ff;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_ff <= ST_RESET;
            cnt_ff <= 32'h0;
            from_sleep_ff <= 1'b0;
            pulse_ff <= 16'h0;
            cyc_ff <= 32'h0;
            cyc_on_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            from_sleep_ff <= nxt_from_sleep;
            pulse_ff <= nxt_pulse;
            cyc_ff <= nxt_cyc;
            cyc_on_ff <= nxt_cyc_on;
            cs_prev_ff <= cs_n;
        end
    end

    // Enables derived from the next state so outputs stay registered
    logic active_n;
    assign active_n = (nxt_state == ST_NORMAL || nxt_state == ST_STANDBY);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            main_regulator_en <= 1'b1;
            main_regulator_lowpwr <= 1'b0;
            second_regulator_drive <= 1'b0;
            high_side_switch <= 1'b0;
            watchdog_run <= 1'b0;
            can_tx_en <= 1'b0;
            fast_osc_sel <= 1'b1;
            reset_n <= 1'b0;
            interrupt_n <= 1'b1;
            mode_state <= 3'h0;
        end else begin
            // Overtemp shuts the regulator off in any mode; sleep shuts it off too
            main_regulator_en <= (nxt_state != ST_SLEEP) && !reg_ot;
            main_regulator_lowpwr <= (nxt_state == ST_STOP);
            second_regulator_drive <= (nxt_state == ST_NORMAL);
            high_side_switch <= (active_n && switch_on_bit) ||
                ((nxt_state == ST_STOP || nxt_state == ST_SLEEP) &&
                 switch_on_bit && nxt_cyc_on);
            watchdog_run <= active_n ||
                (nxt_state == ST_STOP && watchdog_in_stop_bit);
            can_tx_en <= (nxt_state == ST_NORMAL);
            fast_osc_sel <= !(nxt_state == ST_STOP ||
                nxt_state == ST_SLEEP);
            reset_n <= (nxt_state != ST_RESET && nxt_state != ST_SLEEP);
            // Low during wake pulse or while early warning pending in normal/standby
            interrupt_n <= !((nxt_pulse != 16'h0) ||
                (early_warn_flag && active_n));
            mode_state <= nxt_state;
        end
    end

    // Sticky fault flags, second-supply-low follows its detector; a set in the clear cycle wins
    logic ew_set;
    assign ew_set = bat_warn && (state_ff == ST_NORMAL ||
        state_ff == ST_STANDBY);
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            battery_fail_flag <= RST_FLAG;
            early_warn_flag <= RST_FLAG;
            regulator_temp_warning <= RST_FLAG;
            switch_overtemp_flag <= RST_FLAG;
            switch_temp_or_supply_low_flag <= RST_FLAG;
            can_wake_flag <= RST_FLAG;
            second_supply_low_flag <= RST_FLAG;
        end else begin
            battery_fail_flag <= bat_fail ||
                (battery_fail_flag && !flag_clear);
            early_warn_flag <= ew_set ||
                (early_warn_flag && !flag_clear);
            regulator_temp_warning <= reg_ot ||
                (regulator_temp_warning && !flag_clear);
            switch_overtemp_flag <= hs_ot ||
                (switch_overtemp_flag && !flag_clear);
            switch_temp_or_supply_low_flag <= hs_ot || v2_low ||
                (switch_temp_or_supply_low_flag && !flag_clear);
            can_wake_flag <= (can_rx && state_ff != ST_NORMAL) ||
                (can_wake_flag && !flag_clear);
            second_supply_low_flag <= v2_low;
        end
    end

    // Checks
    reset_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == ST_RESET) |-> !reset_n)
        else $error("reset output high in reset state");
    normal_regs_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == ST_NORMAL) |-> second_regulator_drive)
        else $error("second regulator off in normal");
    standby_v2_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == ST_STANDBY) |-> !second_regulator_drive
        && !can_tx_en)
        else $error("standby drives second regulator or can");
    sleep_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == ST_SLEEP) |-> !main_regulator_en)
        else $error("main regulator on in sleep");
    osc_sel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (mode_state == ST_STOP) |-> !fast_osc_sel)
        else $error("fast oscillator in stop");
    battery_fail_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bat_fail |=> battery_fail_flag)
        else $error("battery fail not latched");
    stop_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_ff == ST_STOP && stop_wake && !uv &&
         !(watchdog_in_stop_bit && watchdog_timeout))
        |=> (state_ff == ST_NREQ) && !interrupt_n && reset_n)
        else $error("stop wake missing pulse or request");
    sleep_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_ff == ST_SLEEP && sleep_wake) |=> state_ff == ST_RESET)
        else $error("sleep wake skipped reset");
    wd_fault_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_ff == ST_NORMAL && watchdog_timeout)
        |=> state_ff == ST_RESET)
        else $error("watchdog timeout ignored");
endmodule : opmode_ctrl
`default_nettype wire

// ==== verification/host_model.sv ====
// Host model: sets the watchdog timing in normal request, wakes from
// stop through chip select. Assumes state codes of opmode_pkg.
`default_nettype none
module host_model
    import opmode_pkg::*;
#(
    parameter int unsigned CFG_DELAY = 5
) (
    // Clock and observed state
    input wire logic clk_sys,
    input wire logic [2:0] mode_state,
    // Bench controls
    input wire logic auto_cfg,
    input wire logic cs_wake,
    // Toward the device
    output logic watchdog_timing_write,
    output logic chip_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt = 0;
    int unsigned cs_cnt = 0;
    logic cs_req = 1'h0;
    initial watchdog_timing_write = 1'h0;
    initial chip_select_n = 1'h1;
    // Bench pokes cs_wake on the falling edge; take it on the rising one
    always @(posedge clk_sys) begin
        cs_req <= cs_wake;
    end
    // Driven at the falling edge, away from the sampling edge
    always @(negedge clk_sys) begin
        watchdog_timing_write <= 1'h0;
        if (mode_state != ST_NREQ || !auto_cfg) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
            // Well inside the time-out window
            if (cnt == CFG_DELAY) watchdog_timing_write <= 1'h1;
        end
        // Low, then back high: the rising edge is the wake
        cs_cnt <= cs_req ? 4 : (cs_cnt != 0 ? cs_cnt - 1 : 0);
        chip_select_n <= !(cs_req || cs_cnt != 0);
    end
endmodule : host_model
`default_nettype wire

// ==== verification/sbc_operating_mode_controller_bench.sv ====
// Self-checking bench for the operating-mode controller.
// Assumes shortened counts; the host model answers normal request.
`default_nettype none
module sbc_operating_mode_controller_bench
    import opmode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NRT = 50;
    localparam int RSD = 20;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic [5:0] det = 6'h0;
    logic [3:0] wk = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic [1:0] wd = 2'h0;
    logic mode_req_valid = 1'h0;
    logic [1:0] mode_req = 2'h0;
    logic sw_on = 1'h0;
    logic wd_stop = 1'h0;
    logic flag_clear = 1'h0;
    logic auto_cfg = 1'h1;
    logic cs_wake = 1'h0;
    logic wtw, cs_n, main_en, lowpwr, drv2, hs, wdr, cantx, fosc;
    logic rst_n, int_n, bf, ew, rtw, ssl, sot, tsl, cwf;
    logic [2:0] mode_state;
    int mismatches = 0;
    int checks = 0;
    int unsigned ticks = 0;

    opmode_ctrl #(.NRTOUT_CYCLES(NRT), .RSTDUR_CYCLES(RSD),
        .CYCLIC_CYCLES(8)) i_opmode_ctrl (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .battery_supply_fail(det[0]), .battery_supply_warn(det[1]),
        .regulator_overtemp(det[2]), .second_regulator_low(det[3]),
        .switch_overtemp(det[4]), .main_undervoltage(det[5]),
        .main_overcurrent(wk[0]), .level_wake_inputs(lvl),
        .can_rx_activity(wk[1]), .chip_select_n(cs_n),
        .cyclic_wake(wk[2]), .forced_wake(wk[3]),
        .mode_req_valid(mode_req_valid), .mode_req(mode_req),
        .watchdog_timing_write(wtw), .switch_on_bit(sw_on),
        .watchdog_in_stop_bit(wd_stop), .watchdog_timeout(wd[0]),
        .watchdog_early_trigger(wd[1]), .flag_clear(flag_clear),
        .main_regulator_en(main_en), .main_regulator_lowpwr(lowpwr),
        .second_regulator_drive(drv2), .high_side_switch(hs),
        .watchdog_run(wdr), .can_tx_en(cantx), .fast_osc_sel(fosc),
        .reset_n(rst_n), .interrupt_n(int_n), .battery_fail_flag(bf),
        .early_warn_flag(ew), .regulator_temp_warning(rtw),
        .second_supply_low_flag(ssl), .switch_overtemp_flag(sot),
        .switch_temp_or_supply_low_flag(tsl), .can_wake_flag(cwf),
        .mode_state(mode_state));

    host_model #(.CFG_DELAY(5)) i_host_model (
        .clk_sys(clk_sys), .mode_state(mode_state), .auto_cfg(auto_cfg),
        .cs_wake(cs_wake), .watchdog_timing_write(wtw),
        .chip_select_n(cs_n));

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;

    // Hang guard at 20000 cycles, far beyond the expected run of a few hundred
    always @(posedge clk_sys) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // Bounded wait for a state, then compare
    task automatic wait_mode(input mode_e m, input int lim);
        int n;
        n = 0;
        while (mode_state !== m && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        check(mode_state, m);
    endtask : wait_mode

    // One-cycle mode request, answer a cycle later
    task automatic reqm(input logic [1:0] r, input mode_e m);
        @(negedge clk_sys);
        mode_req_valid = 1'h1;
        mode_req = r;
        @(negedge clk_sys);
        mode_req_valid = 1'h0;
        wait_mode(m, 4);
    endtask : reqm

    initial begin
        int n;
        auto_cfg = 1'h0;
        cyc(6);
        sys_rst = 1'h0;
        n = 0;
        while (rst_n !== 1'h1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= RSD - 1 && n <= RSD + 2, 1'h1);
        check(mode_state, ST_NREQ);
        check({main_en, drv2, hs}, 3'h4);
        n = 0;
        while (mode_state === ST_NREQ && n < 200) begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= NRT - 2 && n <= NRT + 2, 1'h1);
        check(mode_state, ST_RESET);
        auto_cfg = 1'h1;
        wait_mode(ST_NORMAL, 100);
        check({main_en, drv2, wdr, fosc, cantx, lowpwr}, 6'h3e);
        $display("done: power-up and time-out");
        // Fault detectors in normal mode
        det[4:0] = 5'h1f;
        cyc(6);
        check({bf, ew, rtw, ssl, sot, tsl}, 6'h3f);
        check({main_en, int_n}, 2'h0);
        det[4:0] = 5'h0;
        cyc(6);
        check({bf, ssl}, 2'h2);
        flag_clear = 1'h1;
        cyc(1);
        flag_clear = 1'h0;
        cyc(2);
        check(bf, 1'h0);
        $display("done: flags");
        // Watchdog time-out, early trigger, undervoltage
        for (int i = 0; i < 3; i++) begin
            if (i < 2) wd[i] = 1'h1;
            else det[5] = 1'h1;
            cyc(1);
            wd = 2'h0;
            wait_mode(ST_RESET, 6);
            check(rst_n, 1'h0);
            det[5] = 1'h0;
            wait_mode(ST_NORMAL, 150);
        end
        $display("done: reset causes");
        sw_on = 1'h1;
        reqm(REQ_STANDBY, ST_STANDBY);
        cyc(3);
        check({main_en, drv2, cantx, wdr, hs, fosc}, 6'h27);
        wk[1] = 1'h1;
        cyc(4);
        wk[1] = 1'h0;
        check(cwf, 1'h1);
        sw_on = 1'h0;
        cyc(3);
        check(hs, 1'h0);
        reqm(REQ_NORMAL, ST_NORMAL);
        $display("done: standby");
        // Stop, woken by overcurrent, CAN, cyclic and forced wake in turn; chip select last
        for (int k = 0; k < 5; k++) begin
            wd_stop = (k < 2);
            sw_on = 1'h1;
            reqm(REQ_STOP, ST_STOP);
            check({lowpwr, drv2, fosc, wdr}, {3'h4, wd_stop});
            if (k == 0) begin
                n = 0;
                // Supply warning in stop must not latch the early warning
                det[1] = 1'h1;
                repeat (40) begin
                    @(negedge clk_sys);
                    n += hs;
                end
                det[1] = 1'h0;
                check(n > 0 && n < 40, 1'h1);
                check(ew, 1'h0);
            end
            if (k < 4) wk[k] = 1'h1;
            else cs_wake = 1'h1;
            cyc(1);
            cs_wake = 1'h0;
            cyc(3);
            wk = 4'h0;
            wait_mode(ST_NREQ, 12);
            check({rst_n, int_n}, 2'h2);
            wait_mode(ST_NORMAL, 20);
        end
        $display("done: stop wakes");
        reqm(REQ_SLEEP, ST_SLEEP);
        check({main_en, drv2}, 2'h0);
        lvl = 4'h4;
        wait_mode(ST_RESET, 6);
        wait_mode(ST_NREQ, 30);
        wait_mode(ST_NORMAL, 20);
        $display("done: sleep");
        report_and_stop();
    end
endmodule : sbc_operating_mode_controller_bench
`default_nettype wire
